// file: include/iface_cfg_pkg.sv
// Constants and types for the interface configuration register block
package iface_cfg_pkg;
  // Serial command opcodes
  localparam logic [7:0] read_iface_config_cmd = 8'h15;
  localparam logic [7:0] read_wrap_latency_cmd = 8'h33;
  localparam logic [7:0] read_any_reg_cmd = 8'h65;
  localparam logic [7:0] volatile_write_enable_cmd = 8'h50;
  localparam logic [7:0] write_regs_cmd = 8'h01;
  localparam logic [7:0] write_any_reg_cmd = 8'h71;
  localparam logic [7:0] enter_long_addr_cmd = 8'hB7;
  localparam logic [7:0] exit_long_addr_cmd = 8'hE9;
  localparam logic [7:0] enter_wide_protocol_cmd = 8'h38;
  localparam logic [7:0] exit_wide_protocol_cmd = 8'hF5;
  localparam logic [7:0] set_burst_len_cmd = 8'h77;
  // Field positions of the interface configuration register
  localparam int unsigned PIN_RESET_BIT = 7;
  localparam int unsigned DRIVE_HI_BIT = 6;
  localparam int unsigned DRIVE_LO_BIT = 5;
  localparam int unsigned RESERVED_BIT = 4;
  localparam int unsigned WIDE_BIT = 3;
  localparam int unsigned PROT_BIT = 2;
  localparam int unsigned PWRUP_ADDR_BIT = 1;
  localparam int unsigned CUR_ADDR_BIT = 0;
  // Bits that a register write may change (reserved and read-only excluded)
  localparam logic [7:0] IFACE_WRITE_MASK = 8'hED;
  // Wrap enable position in the wrap/latency register, zero means wrapping
  localparam int unsigned WRAP_DISABLE_BIT = 4;
  // Register addresses for the generic read/write commands
  localparam logic [31:0] ADDR_IFACE_VOL = 32'h0000_0010;
  localparam logic [31:0] ADDR_WRAP_VOL = 32'h0000_0020;
  // Data byte positions after the opcode of the multi-register write
  localparam logic [2:0] WRR_IFACE_BYTE = 3'h2;
  localparam logic [2:0] WRR_WRAP_BYTE = 3'h3;
  // Address byte counts
  localparam logic [2:0] ADDR_BYTES_SHORT = 3'h3;
  localparam logic [2:0] ADDR_BYTES_LONG = 3'h4;
  // Bits in a byte and bits taken per edge
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] STEP_SINGLE = 4'h1;
  localparam logic [3:0] STEP_WIDE = 4'h4;
  // Output enable patterns: data on line 1, or on all four lines
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_WIDE = 4'hF;

  // Frame phases
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_WRITE, PH_READ, PH_SKIP} phase_t;
endpackage

// file: core/serial_flash_iface_config_reg.sv
// Interface configuration register with its serial command front end
// What this block does
// - Bit 7 arms pin reset on IO3 when idle
// - Bits 6:5 drive live output strength
// - Bit 3 makes every transfer four wide
// - Wide protocol forces quad active, keeps quad bit
// - Commands 38h/F5h set and clear bit 3
// - No quad: single/dual reads, IO2 protects
// - Quad only: quad reads, IO2 carries data
// - Wide protocol: quad reads, IO2 carries data
// - Bit 2 picks range or per-block protection
// - Bit 1 read-only, shows power-up address length
// - Bit 0 sets current address length
// - Commands B7h/E9h set and clear bit 0
// - Non-volatile length update also updates bit 0
// - Read via 15h/65h, write via 50h+01h/71h
// - Bit 4 reserved, reads zero
// - Burst wrap only for main array reads
// - Resets copy non-volatile wrap/latency setting
// - Wrap register: read 33h, write, 77h
// - Resets load volatile bits from non-volatile
module serial_flash_iface_config_reg
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE,
  input wire logic [7:0] NV_IFACE_CFG,
  input wire logic [7:0] NV_WRAP_LAT,
  input wire logic NV_ADDR_UPDATE,
  input wire logic SOFT_RESET,
  input wire logic QUAD_ENABLE,
  input wire logic ARRAY_READ,
  output logic [1:0] DRIVE_STRENGTH,
  output logic ALL_WIDE_PROTOCOL,
  output logic QUAD_ACTIVE,
  output logic SINGLE_LINE_MODE,
  output logic FOUR_LINE_DATA_MODE,
  output logic IO2_WRITE_PROTECT,
  output logic PROT_BLOCK_LOCK,
  output logic ADDR_4BYTE,
  output logic PIN_RESET_ARMED,
  output logic BURST_WRAP,
  output logic [7:0] WRAP_LATENCY
);
  import iface_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // All state in one record
  typedef struct packed {
    logic cs_s1; // First sync stage, feeds only cs_s2
    logic cs_s2;
    logic cs_prev;
    logic sck_s1;
    logic sck_s2;
    logic sck_prev;
    logic [3:0] io_s1;
    logic [3:0] io_s2;
    phase_t phase;
    logic [7:0] cmd; // Opcode of the current frame
    logic [7:0] sh; // Input shifter
    logic [3:0] bits; // Bits of the current byte
    logic [2:0] nbytes; // Bytes after the opcode or address
    logic [31:0] addr;
    logic wel; // Volatile write enable latch
    logic [7:0] ifc; // interface_config_volatile
    logic [7:0] wrap; // wrap_latency_volatile
    logic [7:0] out_val;
    logic [7:0] out_sh;
    logic [3:0] out_bits;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic quad_active;
    logic single_mode;
    logic four_mode;
    logic wp_pin;
    logic pin_armed;
    logic burst_wrap;
  } state_t;

  state_t st; // Current state
  state_t next_st; // Next state
  logic rise; // Qualified serial clock rising edge
  logic fall; // Qualified serial clock falling edge
  logic frame_end; // Chip select just went high
  logic pin_rst; // IO3 hardware reset seen
  logic reload; // Any reset that reloads the defaults
  logic byte_done; // A whole byte arrived this cycle
  logic [7:0] byte_in; // That byte
  logic wide; // Four bits per edge

  ////////////////////////////////////////////////////////////////////////////
  // Value a generic register read returns for an address
  function automatic logic [7:0] reg_by_addr(input logic [31:0] a, input state_t s);
    if (a == ADDR_IFACE_VOL) begin
      return s.ifc;
    end else if (a == ADDR_WRAP_VOL) begin
      return s.wrap;
    end
    return 8'h00;
  endfunction
  // Merge a written byte into the interface register, protected bits kept
  function automatic logic [7:0] merge_ifc(input logic [7:0] old, input logic [7:0] d);
    return (old & ~IFACE_WRITE_MASK) | (d & IFACE_WRITE_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st = st;
    // Two-stage sync of every pin; edges look at stage two only
    next_st.cs_s1 = CS_N;
    next_st.cs_s2 = st.cs_s1;
    next_st.cs_prev = st.cs_s2;
    next_st.sck_s1 = SCK;
    next_st.sck_s2 = st.sck_s1;
    next_st.sck_prev = st.sck_s2;
    next_st.io_s1 = IO_IN;
    next_st.io_s2 = st.io_s1;
    wide = st.ifc[WIDE_BIT];
    rise = st.sck_s2 & ~st.sck_prev & ~st.cs_s2;
    fall = ~st.sck_s2 & st.sck_prev & ~st.cs_s2;
    frame_end = st.cs_s2 & ~st.cs_prev;
    // IO3 low acts as reset only outside four-wide data use
    pin_rst = st.ifc[PIN_RESET_BIT] & ~st.io_s2[3]
      & (st.cs_s2 | ~st.quad_active | ~wide);
    reload = RST | SOFT_RESET | pin_rst;
    byte_done = 1'b0;
    byte_in = wide ? {st.sh[3:0], st.io_s2} : {st.sh[6:0], st.io_s2[0]};
    // Mode decode, one cycle behind the register
    next_st.quad_active = wide | QUAD_ENABLE;
    next_st.single_mode = ~wide & ~QUAD_ENABLE;
    next_st.four_mode = ~wide & QUAD_ENABLE;
    next_st.wp_pin = ~wide & ~QUAD_ENABLE;
    next_st.pin_armed = st.ifc[PIN_RESET_BIT];
    // Wrap never applies to register or security region reads
    next_st.burst_wrap = ~st.wrap[WRAP_DISABLE_BIT] & ARRAY_READ;
    if (reload) begin
      // Defaults from the non-volatile copies
      next_st.ifc = {NV_IFACE_CFG[7:5], 1'b0, NV_IFACE_CFG[3:2],
        NV_IFACE_CFG[1], NV_IFACE_CFG[1]};
      next_st.wrap = NV_WRAP_LAT;
      next_st.phase = PH_CMD;
      next_st.bits = 4'h0;
      next_st.nbytes = 3'h0;
      next_st.wel = 1'b0;
      next_st.io_oe = 4'h0;
      next_st.io_out = 4'h0;
      next_st.out_bits = 4'h0;
    end else begin
      // Non-volatile length update drags the current length along
      if (NV_ADDR_UPDATE) begin
        next_st.ifc[PWRUP_ADDR_BIT] = NV_IFACE_CFG[PWRUP_ADDR_BIT];
        next_st.ifc[CUR_ADDR_BIT] = NV_IFACE_CFG[PWRUP_ADDR_BIT];
      end
      if (frame_end) begin
        // Frame over: release pins; a 01h/71h frame consumes the write enable
        next_st.phase = PH_CMD;
        next_st.bits = 4'h0;
        next_st.nbytes = 3'h0;
        next_st.io_oe = 4'h0;
        if (st.cmd == write_regs_cmd || st.cmd == write_any_reg_cmd) begin
          next_st.wel = 1'b0;
        end
      end else if (rise && st.phase != PH_READ && st.phase != PH_SKIP) begin
        // Collect input bits, one or four per edge
        next_st.sh = byte_in;
        next_st.bits = st.bits + (wide ? STEP_WIDE : STEP_SINGLE);
        if (next_st.bits == BYTE_BITS) begin
          byte_done = 1'b1;
          next_st.bits = 4'h0;
        end
      end else if (fall && st.phase == PH_READ) begin
        // Shift out the next bits; the register repeats while clocked
        next_st.out_bits = st.out_bits + (wide ? STEP_WIDE : STEP_SINGLE);
        next_st.out_sh = wide ? {st.out_sh[3:0], 4'h0} : {st.out_sh[6:0], 1'b0};
        if (next_st.out_bits == BYTE_BITS) begin
          next_st.out_bits = 4'h0;
          next_st.out_sh = st.out_val;
        end
        next_st.io_out = wide ? next_st.out_sh[7:4] : {2'b00, next_st.out_sh[7], 1'b0};
      end
      if (byte_done) begin
        case (st.phase)
          // Opcode byte
          PH_CMD: begin
            next_st.cmd = byte_in;
            next_st.phase = PH_SKIP;
            next_st.addr = 32'h0;
            case (byte_in)
              read_iface_config_cmd: begin
                next_st.out_val = st.ifc;
                next_st.phase = PH_READ;
              end
              read_wrap_latency_cmd: begin
                next_st.out_val = st.wrap;
                next_st.phase = PH_READ;
              end
              read_any_reg_cmd, write_any_reg_cmd: begin
                next_st.phase = PH_ADDR;
              end
              write_regs_cmd, set_burst_len_cmd: begin
                next_st.phase = PH_WRITE;
              end
              volatile_write_enable_cmd: begin
                next_st.wel = 1'b1;
              end
              enter_long_addr_cmd: begin
                next_st.ifc[CUR_ADDR_BIT] = 1'b1;
              end
              exit_long_addr_cmd: begin
                next_st.ifc[CUR_ADDR_BIT] = 1'b0;
              end
              enter_wide_protocol_cmd: begin
                next_st.ifc[WIDE_BIT] = 1'b1;
              end
              exit_wide_protocol_cmd: begin
                next_st.ifc[WIDE_BIT] = 1'b0;
              end
              default: begin
                next_st.phase = PH_SKIP;
              end
            endcase
            if (next_st.phase == PH_READ) begin
              // Bit 7 shown early; the count makes the opcode's last fall reload it
              next_st.out_sh = next_st.out_val;
              next_st.out_bits = BYTE_BITS - (wide ? STEP_WIDE : STEP_SINGLE);
              next_st.io_oe = wide ? OE_WIDE : OE_SINGLE;
              next_st.io_out = wide ? next_st.out_val[7:4]
                : {2'b00, next_st.out_val[7], 1'b0};
            end
          end
          // Address bytes, length set by the current length bit
          PH_ADDR: begin
            next_st.addr = {st.addr[23:0], byte_in};
            next_st.nbytes = st.nbytes + 3'h1;
            if (next_st.nbytes == (st.ifc[CUR_ADDR_BIT] ? ADDR_BYTES_LONG
                : ADDR_BYTES_SHORT)) begin
              next_st.nbytes = 3'h0;
              if (st.cmd == read_any_reg_cmd) begin
                next_st.out_val = reg_by_addr(next_st.addr, st);
                next_st.out_sh = next_st.out_val;
                next_st.out_bits = BYTE_BITS - (wide ? STEP_WIDE : STEP_SINGLE);
                next_st.io_oe = wide ? OE_WIDE : OE_SINGLE;
                next_st.io_out = wide ? next_st.out_val[7:4]
                  : {2'b00, next_st.out_val[7], 1'b0};
                next_st.phase = PH_READ;
              end else begin
                next_st.phase = PH_WRITE;
              end
            end
          end
          // Data bytes of the write commands
          PH_WRITE: begin
            next_st.nbytes = st.nbytes + 3'h1;
            if (st.cmd == set_burst_len_cmd) begin
              next_st.wrap = byte_in;
              next_st.phase = PH_SKIP;
            end else if (st.cmd == write_regs_cmd) begin
              if (st.wel && st.nbytes == WRR_IFACE_BYTE) begin
                next_st.ifc = merge_ifc(st.ifc, byte_in);
              end
              if (st.wel && st.nbytes == WRR_WRAP_BYTE) begin
                next_st.wrap = byte_in;
              end
            end else begin
              if (st.wel && st.addr == ADDR_IFACE_VOL) begin
                next_st.ifc = merge_ifc(st.ifc, byte_in);
              end
              if (st.wel && st.addr == ADDR_WRAP_VOL) begin
                next_st.wrap = byte_in;
              end
              next_st.phase = PH_SKIP;
            end
          end
          default: begin
            next_st.phase = PH_SKIP;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; synchronous reset handled in the next-state logic
  always_ff @(posedge CLK) begin
    st <= next_st;
  end

  // Outputs straight from the state flops
  assign IO_OUT = st.io_out;
  assign IO_OE = st.io_oe;
  assign DRIVE_STRENGTH = st.ifc[DRIVE_HI_BIT:DRIVE_LO_BIT];
  assign ALL_WIDE_PROTOCOL = st.ifc[WIDE_BIT];
  assign QUAD_ACTIVE = st.quad_active;
  assign SINGLE_LINE_MODE = st.single_mode;
  assign FOUR_LINE_DATA_MODE = st.four_mode;
  assign IO2_WRITE_PROTECT = st.wp_pin;
  assign PROT_BLOCK_LOCK = st.ifc[PROT_BIT];
  assign ADDR_4BYTE = st.ifc[CUR_ADDR_BIT];
  assign PIN_RESET_ARMED = st.pin_armed;
  assign BURST_WRAP = st.burst_wrap;
  assign WRAP_LATENCY = st.wrap;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_wide_enter: assert property (byte_done && st.phase == PH_CMD && byte_in == 8'h38
    && !NV_ADDR_UPDATE |=> st.ifc[3]) else $error("wide entry missed");
  a_wide_exit: assert property (byte_done && st.phase == PH_CMD && byte_in == 8'hF5
    |=> !st.ifc[3] || $past(reload)) else $error("wide exit missed");
  a_long_enter: assert property (byte_done && st.phase == PH_CMD && byte_in == 8'hB7
    && !NV_ADDR_UPDATE |=> st.ifc[0]) else $error("long addr entry missed");
  a_long_exit: assert property (byte_done && st.phase == PH_CMD && byte_in == 8'hE9
    && !NV_ADDR_UPDATE |=> !st.ifc[0]) else $error("long addr exit missed");
  a_pwrup_ro: assert property ($changed(st.ifc[1])
    |-> $past(reload || NV_ADDR_UPDATE)) else $error("read-only length bit changed");
  a_nv_follow: assert property (NV_ADDR_UPDATE && !reload && !byte_done
    |=> st.ifc[0] == st.ifc[1]) else $error("current length not updated");
  a_quad_force: assert property (st.ifc[3] ##1 st.ifc[3]
    |-> QUAD_ACTIVE && !IO2_WRITE_PROTECT) else $error("wide protocol without quad");
  a_rsvd_zero: assert property (st.ifc[4] == 1'b0) else $error("reserved bit set");
  a_pin_reset: assert property (st.ifc[7] && !st.io_s2[3] && st.cs_s2
    |=> st.ifc[7:5] == $past(NV_IFACE_CFG[7:5])) else $error("pin reset missed");
  a_reset_load: assert property (disable iff (1'b0) RST |=> st.ifc[7:5] ==
    $past(NV_IFACE_CFG[7:5]) && st.wrap == $past(NV_WRAP_LAT)) else $error("bad reload");
  c_read_cfg: cover property (byte_done && st.phase == PH_CMD && byte_in == 8'h15);
  c_wide_mode: cover property (st.ifc[3] && byte_done);
  c_write_any: cover property (byte_done && st.phase == PH_WRITE && st.wel);
  c_pin_reset: cover property (pin_rst);
endmodule

// file: verif/spi_host_model.sv
// Host-side serial command model that drives the flash pins
module spi_host_model (
  input wire logic CLK,
  output logic CS_N,
  output logic SCK,
  output logic [3:0] IO_IN,
  input wire logic [3:0] IO_OUT,
  input wire logic [3:0] IO_OE
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] drv; // Host side of each line
  logic [7:0] txq[$]; // Bytes of the next frame
  logic wide; // Four lines per edge once switched

  ////////////////////////////////////////////////////////////////////////////
  // Wire level: the device wins wherever it drives
  assign IO_IN = (IO_OE & IO_OUT) | (~IO_OE & drv);

  // Idle: clock parked low, reset line held high
  initial begin
    CS_N = 1'b1;
    SCK = 1'b0;
    drv = 4'hF;
    wide = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait a number of falling clock edges
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask

  // One frame: send queued bytes, then clock in one whole byte when nrd is nonzero
  // Low phase 5 cycles, high 3: keeps 3+ cycles between link edges
  task automatic frame(input int nrd, output logic [7:0] rd);
    int step;
    logic [7:0] b;
    step = wide ? 4 : 1;
    rd = 8'h00;
    cyc(1);
    CS_N = 1'b0;
    while (txq.size() > 0) begin
      b = txq.pop_front();
      for (int i = 7; i >= 0; i -= step) begin
        // Nibble on all lines when wide, else one bit on line 0
        if (wide) begin
          drv = b[i -: 4];
        end else begin
          drv[0] = b[i];
        end
        cyc(5);
        SCK = 1'b1;
        cyc(3);
        SCK = 1'b0;
      end
    end
    // Lines 2:0 show the inverse and line 3 stays high, so a stale value cannot pass
    drv = {1'b1, ~drv[2:0]};
    for (int i = 7; i >= 0 && nrd > 0; i -= step) begin
      cyc(5);
      // Mode 0: sample just before the rising edge
      if (wide) begin
        rd[i -: 4] = IO_IN;
      end else begin
        rd[i] = IO_IN[1];
      end
      SCK = 1'b1;
      cyc(3);
      SCK = 1'b0;
    end
    cyc(2);
    CS_N = 1'b1;
    cyc(10);
  endtask

  // Pull the shared reset line low while deselected
  task automatic pin_reset();
    cyc(1);
    drv[3] = 1'b0;
    cyc(4);
    drv[3] = 1'b1;
    cyc(10);
  endtask
endmodule

// file: verif/test_serial_flash_iface_config_reg.sv
// Self-checking bench for the interface configuration register block
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); \
  end \
end

module test_serial_flash_iface_config_reg
  import iface_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sck;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] nv_iface = 8'h62; // Pin reset off, drive 11, short power-up off
  logic [7:0] nv_wrap = 8'h70; // Wrap disabled at boot
  logic nv_addr_update = 1'b0;
  logic soft_reset = 1'b0;
  logic quad_enable = 1'b0;
  logic array_read = 1'b1;
  logic [1:0] drive_strength;
  logic all_wide, quad_active, single_mode, four_line, io2_wp;
  logic prot_lock, addr_4byte, pin_armed, burst_wrap;
  logic [7:0] wrap_latency;
  logic [7:0] rdv; // Last byte read back
  int err_count = 0;
  int num_checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  always #25 clk = ~clk;

  serial_flash_iface_config_reg i_serial_flash_iface_config_reg (
    .CLK(clk), .RST(rst), .CS_N(cs_n), .SCK(sck), .IO_IN(io_in),
    .IO_OUT(io_out), .IO_OE(io_oe), .NV_IFACE_CFG(nv_iface),
    .NV_WRAP_LAT(nv_wrap), .NV_ADDR_UPDATE(nv_addr_update),
    .SOFT_RESET(soft_reset), .QUAD_ENABLE(quad_enable),
    .ARRAY_READ(array_read), .DRIVE_STRENGTH(drive_strength),
    .ALL_WIDE_PROTOCOL(all_wide), .QUAD_ACTIVE(quad_active),
    .SINGLE_LINE_MODE(single_mode), .FOUR_LINE_DATA_MODE(four_line),
    .IO2_WRITE_PROTECT(io2_wp), .PROT_BLOCK_LOCK(prot_lock),
    .ADDR_4BYTE(addr_4byte), .PIN_RESET_ARMED(pin_armed),
    .BURST_WRAP(burst_wrap), .WRAP_LATENCY(wrap_latency)
  );

  spi_host_model i_spi_host_model (
    .CLK(clk), .CS_N(cs_n), .SCK(sck), .IO_IN(io_in),
    .IO_OUT(io_out), .IO_OE(io_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wait falling edges, where inputs change
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Frame with no read data
  task automatic run(input logic [7:0] q[$]);
    i_spi_host_model.txq = q;
    i_spi_host_model.frame(0, rdv);
  endtask

  // Frame that reads one byte and compares it
  task automatic rd(input logic [7:0] q[$], input logic [7:0] exp);
    i_spi_host_model.txq = q;
    i_spi_host_model.frame(1, rdv);
    `CHK(rdv, exp)
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  // Single exit point for pass and fail
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog against a hung frame
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("ERROR %0t: run timed out", $time);
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    step(20);
    rst = 1'b0;
    step(2);
    // Defaults copied from the non-volatile images
    rd('{read_iface_config_cmd}, 8'h63);
    rd('{read_wrap_latency_cmd}, 8'h70);
    `CHK(drive_strength, 2'h3)
    `CHK(addr_4byte, 1'b1)
    `CHK(burst_wrap, 1'b0)
    fin("reset");
    // Address length commands
    run('{exit_long_addr_cmd});
    `CHK(addr_4byte, 1'b0)
    rd('{read_iface_config_cmd}, 8'h62);
    run('{enter_long_addr_cmd});
    `CHK(addr_4byte, 1'b1)
    fin("addr_length");
    // Write refused without enable, then accepted; 4-byte address in use
    run('{write_any_reg_cmd, 8'h00, 8'h00, 8'h00, 8'h10, 8'h95});
    rd('{read_any_reg_cmd, 8'h00, 8'h00, 8'h00, 8'h10}, 8'h63);
    run('{volatile_write_enable_cmd});
    run('{write_any_reg_cmd, 8'h00, 8'h00, 8'h00, 8'h10, 8'h95});
    rd('{read_iface_config_cmd}, 8'h87);
    `CHK(drive_strength, 2'h0)
    `CHK(prot_lock, 1'b1)
    `CHK(pin_armed, 1'b1)
    fin("write_any");
    // Armed pin reset reloads; disarmed pin does nothing
    i_spi_host_model.pin_reset();
    rd('{read_iface_config_cmd}, 8'h63);
    `CHK(pin_armed, 1'b0)
    run('{exit_long_addr_cmd});
    i_spi_host_model.pin_reset();
    `CHK(addr_4byte, 1'b0)
    fin("pin_reset");
    // Multi-register write, enable consumed by it; 3-byte address now
    run('{volatile_write_enable_cmd});
    run('{write_regs_cmd, 8'h00, 8'h00, 8'h20, 8'h55});
    run('{write_regs_cmd, 8'h00, 8'h00, 8'h63, 8'hAA});
    rd('{read_any_reg_cmd, 8'h00, 8'h00, 8'h10}, 8'h22);
    rd('{read_any_reg_cmd, 8'h00, 8'h00, 8'h20}, 8'h55);
    `CHK(drive_strength, 2'h1)
    fin("write_regs");
    // Burst length command and wrap gating by target
    run('{set_burst_len_cmd, 8'h0A});
    `CHK(wrap_latency, 8'h0A)
    `CHK(burst_wrap, 1'b1)
    array_read = 1'b0;
    step(4);
    `CHK(burst_wrap, 1'b0)
    fin("wrap");
    // Line modes with the wide protocol off
    for (int q = 0; q < 2; q++) begin
      quad_enable = q[0];
      step(4);
      `CHK(single_mode, ~q[0])
      `CHK(io2_wp, ~q[0])
      `CHK(four_line, q[0])
      `CHK(quad_active, q[0])
    end
    // Enter wide protocol, read in it, leave it
    quad_enable = 1'b0;
    run('{enter_wide_protocol_cmd});
    `CHK(all_wide, 1'b1)
    `CHK(quad_active, 1'b1)
    `CHK({single_mode, io2_wp, four_line}, 3'h0)
    i_spi_host_model.wide = 1'b1;
    rd('{read_iface_config_cmd}, 8'h2A);
    run('{exit_wide_protocol_cmd});
    i_spi_host_model.wide = 1'b0;
    `CHK(all_wide, 1'b0)
    `CHK(quad_active, 1'b0)
    fin("modes");
    // Non-volatile length update, then software reset
    run('{enter_long_addr_cmd});
    nv_iface = 8'h60;
    nv_addr_update = 1'b1;
    step(1);
    nv_addr_update = 1'b0;
    step(4);
    `CHK(addr_4byte, 1'b0)
    soft_reset = 1'b1;
    step(1);
    soft_reset = 1'b0;
    step(4);
    rd('{read_iface_config_cmd}, 8'h60);
    `CHK(wrap_latency, 8'h70)
    fin("nv_update");
    tally_and_finish();
  end
endmodule
